// ---- core/drq_ctrl.v ----
// decimation / requantizer control register and its decode into the
// post-processing chain of a high-speed converter.
// assumes the serial control port delivers decoded 8-bit register writes
// and reads synchronous to core_clk_i, and that the neighbouring
// registers (filter-A upper code, requantizer settings, reset toggle,
// dual-channel enable) arrive as plain inputs.
//
// Summary of operation
// - register settings act only in single- or dual-channel mode.
// - bit 6 high switches in first 2x decimation stage in single mode.
// - bit 6 is the lowest bit of the filter-A stage code.
// - dual mode uses the channel-B filter setting only for channel B.
// - any edge of the shared reset toggle clears both requantizers.
// - a change of a requantizer filter setting clears its state.
// - dual-channel post-processing runs only while its enable is 1.
`timescale 1ns/1ps
`default_nettype none
`include "drq_regs.vh"

module drq_ctrl #(
  parameter CODE_W = 9,
  parameter SET_W = 7
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [1:0] chan_mode_i,
  input wire [CODE_W-2:0] filter_a_stage_code_upper_i,
  input wire [SET_W-1:0] chan_a_requant_filter_setting_i,
  input wire [SET_W-1:0] chan_b_requant_filter_setting_i,
  input wire requant_state_reset_toggle_i,
  input wire dual_channel_postproc_enable_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  output reg [CODE_W-1:0] filter_a_code_o,
  output reg [3:0] filter_a_stages_o,
  output reg filter_a_code_bad_o,
  output reg filter_a_first_stage_enable_o,
  output reg fractional_delay_enable_o,
  output reg [1:0] chan_a_requant_enable_o,
  output reg [1:0] chan_b_requant_enable_o,
  output reg [SET_W-1:0] chan_a_filter_o,
  output reg [SET_W-1:0] chan_b_filter_o,
  output reg dual_postproc_active_o,
  output reg chan_a_requant_clear_o,
  output reg chan_b_requant_clear_o
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // number of set bits of a stage code
  function [3:0] ones_count;
    input [CODE_W-1:0] code;
    integer i;
    begin
      ones_count = 4'h0;
      for (i = 0; i < CODE_W; i = i + 1)
        ones_count = ones_count + {3'h0, code[i]};
    end
  endfunction

  // a thermometer code has all its ones packed at the bottom
  function thermo_ok;
    input [CODE_W-1:0] code;
    begin
      thermo_ok = ((code & (code + {{(CODE_W-1){1'b0}}, 1'b1})) ==
                   {CODE_W{1'b0}});
    end
  endfunction

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------

  reg [7:0] ctrl_q;
  reg [7:0] ctrl_d;
  wire hit;

  assign hit = (reg_addr_i == `DRQ_ADDR_CTRL);

  // all eight bits are plain read/write; factory bits simply hold
  // whatever software leaves in them, which should be the reset value
  always @*
  begin
    ctrl_d = ctrl_q;
    if (reg_wr_i && hit)
      ctrl_d = reg_wdata_i;
  end

  always @(posedge core_clk_i)
  begin
    if (rst_i)
      ctrl_q <= `DRQ_CTRL_RESET;
    else
      ctrl_q <= ctrl_d;
  end

  // read port: the register on a hit, zero elsewhere
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      reg_rdata_o <= (reg_rd_i && hit) ? ctrl_q : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // mode qualification and stage code
  // ----------------------------------------------------------------

  wire mode_single;
  wire mode_dual;
  wire mode_ok;
  wire dual_run;
  wire [CODE_W-1:0] code_full;

  assign mode_single = (chan_mode_i == `DRQ_MODE_SINGLE);
  assign mode_dual = (chan_mode_i == `DRQ_MODE_DUAL);
  assign mode_ok = mode_single | mode_dual;
  // dual-mode post-processing only behind its enable
  assign dual_run = mode_dual & dual_channel_postproc_enable_i;
  // low bit of the stage code comes from this register
  assign code_full = {filter_a_stage_code_upper_i,
                      ctrl_q[`DRQ_BIT_FILTER_A_FIRST]};

  // ----------------------------------------------------------------
  // requantizer state clear on toggle or setting change
  // ----------------------------------------------------------------

  reg toggle_prev_q;
  reg [SET_W-1:0] set_a_prev_q;
  reg [SET_W-1:0] set_b_prev_q;
  wire toggle_edge;
  wire set_a_change;
  wire set_b_change;

  assign toggle_edge = toggle_prev_q ^ requant_state_reset_toggle_i;
  assign set_a_change = (set_a_prev_q != chan_a_requant_filter_setting_i);
  assign set_b_change = (set_b_prev_q != chan_b_requant_filter_setting_i);

  // previous values, cleared to the neighbours' reset values
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      toggle_prev_q <= 1'b0;
      set_a_prev_q <= {SET_W{1'b0}};
      set_b_prev_q <= {SET_W{1'b0}};
    end
    else
    begin
      toggle_prev_q <= requant_state_reset_toggle_i;
      set_a_prev_q <= chan_a_requant_filter_setting_i;
      set_b_prev_q <= chan_b_requant_filter_setting_i;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs to the processing chain
  // ----------------------------------------------------------------

  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      filter_a_code_o <= {CODE_W{1'b0}};
      filter_a_stages_o <= 4'h0;
      filter_a_code_bad_o <= 1'b0;
      filter_a_first_stage_enable_o <= 1'b0;
      fractional_delay_enable_o <= 1'b0;
      chan_a_requant_enable_o <= 2'h0;
      chan_b_requant_enable_o <= 2'h0;
      chan_a_filter_o <= {SET_W{1'b0}};
      chan_b_filter_o <= {SET_W{1'b0}};
      dual_postproc_active_o <= 1'b0;
      chan_a_requant_clear_o <= 1'b0;
      chan_b_requant_clear_o <= 1'b0;
    end
    else
    begin
      // stage code and its thermometer decode
      filter_a_code_o <= mode_ok ? code_full : {CODE_W{1'b0}};
      filter_a_stages_o <= (mode_ok && thermo_ok(code_full)) ?
                           ones_count(code_full) : 4'h0;
      filter_a_code_bad_o <= mode_ok & ~thermo_ok(code_full);
      // first 2x stage only in single mode, bypassed otherwise
      filter_a_first_stage_enable_o <= mode_single &
        ctrl_q[`DRQ_BIT_FILTER_A_FIRST];
      fractional_delay_enable_o <= mode_ok &
        ctrl_q[`DRQ_BIT_FRAC_DELAY];
      chan_a_requant_enable_o <= mode_ok ?
        {ctrl_q[`DRQ_BIT_CHAN_A_FIRST],
         ctrl_q[`DRQ_BIT_CHAN_A_SECOND]} : 2'h0;
      // channel B exists only while dual processing runs
      chan_b_requant_enable_o <= dual_run ?
        {ctrl_q[`DRQ_BIT_CHAN_B_FIRST],
         ctrl_q[`DRQ_BIT_CHAN_B_SECOND]} : 2'h0;
      chan_a_filter_o <= mode_ok ?
        chan_a_requant_filter_setting_i : {SET_W{1'b0}};
      chan_b_filter_o <= dual_run ?
        chan_b_requant_filter_setting_i : {SET_W{1'b0}};
      dual_postproc_active_o <= dual_run;
      // one-cycle clears of requantizer state
      chan_a_requant_clear_o <= toggle_edge | set_a_change;
      chan_b_requant_clear_o <= toggle_edge | set_b_change;
    end
  end

endmodule

`default_nettype wire

// ---- inc/drq_regs.vh ----
// register map and field positions of the decimation and requantizer
// control register; included by the control block.
// assumes an 8-bit register address space on the serial control port.
`ifndef DRQ_REGS_VH
`define DRQ_REGS_VH

// register address and reset value
`define DRQ_ADDR_CTRL 8'h7A
`define DRQ_CTRL_RESET 8'h00

// field positions inside the control register
`define DRQ_BIT_FACTORY_HIGH 7
`define DRQ_BIT_FILTER_A_FIRST 6
`define DRQ_BIT_FRAC_DELAY 5
`define DRQ_BIT_FACTORY_LOW 4
`define DRQ_BIT_CHAN_B_FIRST 3
`define DRQ_BIT_CHAN_B_SECOND 2
`define DRQ_BIT_CHAN_A_FIRST 1
`define DRQ_BIT_CHAN_A_SECOND 0

// channel mode encodings
`define DRQ_MODE_SINGLE 2'h0
`define DRQ_MODE_DUAL 2'h1

`endif

// ---- verification/drq_ctrl_assertions.sv ----
// checker on the ports of the decimation and requantizer control block
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module drq_chk #(parameter CODE_W = 9, parameter SET_W = 7) (
  input wire core_clk_i, input wire rst_i, input wire reg_rd_i,
  input wire [1:0] chan_mode_i,
  input wire [CODE_W-2:0] filter_a_stage_code_upper_i,
  input wire [SET_W-1:0] chan_a_requant_filter_setting_i,
  input wire requant_state_reset_toggle_i,
  input wire dual_channel_postproc_enable_i, input wire reg_rvalid_o,
  input wire [CODE_W-1:0] filter_a_code_o, input wire [3:0] filter_a_stages_o,
  input wire filter_a_code_bad_o, input wire filter_a_first_stage_enable_o,
  input wire fractional_delay_enable_o,
  input wire [1:0] chan_a_requant_enable_o,
  input wire [1:0] chan_b_requant_enable_o,
  input wire [SET_W-1:0] chan_b_filter_o, input wire dual_postproc_active_o,
  input wire chan_a_requant_clear_o, input wire chan_b_requant_clear_o
);
  // -------------------------------------------------------------
  // properties
  // -------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe without valid");
  first_stage_a: assert property (
    filter_a_first_stage_enable_o |-> $past(chan_mode_i) == 2'h0)
    else $error("first stage outside single mode");
  mode_gate_a: assert property ($past(chan_mode_i) >= 2'h2 |->
    filter_a_code_o == '0 && chan_a_requant_enable_o == 2'h0
    && !fractional_delay_enable_o) else $error("settings act in other mode");
  code_upper_a: assert property ($past(chan_mode_i) < 2'h2 |->
    filter_a_code_o[CODE_W-1:1] == $past(filter_a_stage_code_upper_i))
    else $error("stage code upper bits wrong");
  therm_bad_a: assert property (
    filter_a_code_bad_o |-> filter_a_stages_o == 4'h0)
    else $error("stage count on bad code");
  dual_active_a: assert property (dual_postproc_active_o ==
    ($past(chan_mode_i) == 2'h1 && $past(dual_channel_postproc_enable_i)))
    else $error("dual post-processing state wrong");
  chan_b_gate_a: assert property (!dual_postproc_active_o |->
    chan_b_requant_enable_o == 2'h0 && chan_b_filter_o == '0)
    else $error("channel b active while off");
  toggle_clear_a: assert property ($changed(requant_state_reset_toggle_i)
    |=> chan_a_requant_clear_o && chan_b_requant_clear_o)
    else $error("toggle edge without clears");
  setting_clear_a: assert property (
    $changed(chan_a_requant_filter_setting_i) |=> chan_a_requant_clear_o)
    else $error("setting change without clear");
  cover property (filter_a_first_stage_enable_o);
  cover property (chan_a_requant_clear_o && chan_b_requant_clear_o);
  cover property (filter_a_code_bad_o);
endmodule
bind drq_ctrl drq_chk #(.CODE_W(CODE_W), .SET_W(SET_W)) u_chk (.*);
`default_nettype wire

// ---- verification/drq_ctrl_tb.sv ----
// self-checking bench of the decimation and requantizer control block
// assumes the block is driven alone, inputs changed at falling edges
`timescale 1ns/1ps
`default_nettype none
module drq_ctrl_tb;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tog = 1'b0, den = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, upper = 8'h00, rdata, d;
  logic [1:0] mode = 2'h0, aen, ben;
  logic [6:0] sa = 7'h00, sb = 7'h00, fa, fb;
  logic [8:0] code;
  logic [3:0] stg;
  logic bad, fst, fde, act, ca, cb, rv, ok, dual;
  logic [7:0] rq[$];
  int n_fail = 0, n_tests = 0;
  // -------------------------------------------------------------
  // clock, block and helpers
  // -------------------------------------------------------------
  always #20 clk = ~clk;
  drq_ctrl u_dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .chan_mode_i(mode),
    .filter_a_stage_code_upper_i(upper), .chan_a_requant_filter_setting_i(sa),
    .chan_b_requant_filter_setting_i(sb), .requant_state_reset_toggle_i(tog),
    .dual_channel_postproc_enable_i(den), .reg_rdata_o(rdata),
    .reg_rvalid_o(rv), .filter_a_code_o(code), .filter_a_stages_o(stg),
    .filter_a_code_bad_o(bad), .filter_a_first_stage_enable_o(fst),
    .fractional_delay_enable_o(fde), .chan_a_requant_enable_o(aen),
    .chan_b_requant_enable_o(ben), .chan_a_filter_o(fa), .chan_b_filter_o(fb),
    .dual_postproc_active_o(act), .chan_a_requant_clear_o(ca),
    .chan_b_requant_clear_o(cb));
  task automatic cmp_out(input logic [8:0] g, input logic [8:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %0t output %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
    cmp_out({1'b0, g}, {1'b0, e});
  endtask
  // one-cycle strobes, held until the taking edge has passed, then one
  // idle edge so that back-to-back calls never re-raise in the same step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    addr = a; wd = v; wr = 1'b1;
    @(negedge clk) wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    addr = a; rd = 1'b1; rq.push_back(e);
    @(negedge clk) rd = 1'b0;
    @(negedge clk);
  endtask
  // stage count of a thermometer code, zero for any other code
  function automatic logic [3:0] ones(input logic [8:0] c);
    ones = 4'h0;
    if ((c & (c + 9'h001)) == 9'h000)
      for (int i = 0; i < 9; i++) ones += {3'h0, c[i]};
  endfunction
  task automatic close_out;
    // a read that never got its answer counts as a mismatch
    if (rq.size() != 0)
      n_fail++;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // read data monitor takes the oldest expectation
  always @(posedge clk)
  begin
    if (rv === 1'b1)
    begin
      if (rq.size() == 0)
      begin
        n_fail++;
        $display("Error %0t read answer without request", $time);
      end
      else
        cmp_rd(rdata, rq.pop_front());
    end
  end
  initial
  begin
    #100000 n_fail++;
    close_out();
  end
  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial
  begin
    void'($urandom(78));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd_reg(8'h7A, 8'h00);
    wr_reg(8'h7B, 8'hFF);
    rd_reg(8'h7A, 8'h00);
    rd_reg(8'h7B, 8'h00);
    $display("reset and unmapped test done");
    for (int i = 0; i < 24; i++)
    begin
      mode = 2'(i); den = 1'($urandom); sa = 7'($urandom); sb = 7'($urandom);
      d = 8'($urandom) & 8'h6F;
      if (mode == 2'h1) d[6] = 1'b0;
      upper = i[2] ? 8'($urandom) : 8'hFF >> ($urandom % 9);
      wr_reg(8'h7A, d);
      @(negedge clk);
      ok = !mode[1];
      dual = mode == 2'h1 && den;
      cmp_out(code, ok ? {upper, d[6]} : 9'h000);
      cmp_out({4'h0, bad, stg}, ok ? {4'h0, ones({upper, d[6]}) == 4'h0
        && {upper, d[6]} != 9'h000, ones({upper, d[6]})} : 9'h000);
      cmp_out({fst, fde, aen, ben, act, 2'h0}, {d[6] && mode == 2'h0,
        d[5] && ok, ok ? d[1:0] : 2'h0, dual ? d[3:2] : 2'h0, dual,
        2'h0});
      cmp_out({fa, 2'h0}, {ok ? sa : 7'h00, 2'h0});
      cmp_out({fb, 2'h0}, {dual ? sb : 7'h00, 2'h0});
      rd_reg(8'h7A, d);
    end
    $display("field decode test done");
    mode = 2'h0;
    tog = ~tog;
    @(negedge clk);
    cmp_out({7'h00, ca, cb}, 9'h003);
    sa = sa + 7'h01;
    @(negedge clk);
    cmp_out({7'h00, ca, cb}, 9'h002);
    sb = sb + 7'h01;
    @(negedge clk);
    cmp_out({7'h00, ca, cb}, 9'h001);
    @(negedge clk);
    cmp_out({7'h00, ca, cb}, 9'h000);
    tog = ~tog;
    @(negedge clk);
    cmp_out({7'h00, ca, cb}, 9'h003);
    @(negedge clk);
    cmp_out({7'h00, ca, cb}, 9'h000);
    $display("requantizer clear test done");
    close_out();
  end
endmodule
`default_nettype wire
